// >>> dpbc_command_decode.v
`timescale 1ns/1ps
`include "dpbc_map.vh"

//------------------------------------------------------------------
// Contract
// - Answer matching, CRC-valid reserved command codes
// - Reply echoes address, code, fresh check byte
// - Drop reserved command for other address silently
// - Init flag set enables periodic mode
// - Periodic mode decodes broadcast reads and fragments
// - Same bit encoding and word layout everywhere
// - Diag off: answer only one-bit commands
// - Either bit value is a broadcast read
// - Fragments are 2 or 4 bits per select
// - Diag on: answer exactly reads and fragments
// - Read or odd length clears partial command
// - Diag command only after 32 valid bits
// - Assembled command checked with same CRC
// - No error check on broadcast reads
// - Init flag cleared only by reset
// - Periodic disables command mode; diag needs enable
//------------------------------------------------------------------
module dpbc_command_decode (
  // Clock and reset
  input wire MCLK,
  input wire RST_B,
  // Received command from the bit decoder
  input wire CMD_VALID,
  input wire [5:0] CMD_LEN,
  input wire [31:0] CMD_DATA,
  // Configuration
  input wire [3:0] NODE_ADDRESS_REG,
  input wire DIAG_MODE_ENABLE,
  input wire FRAGMENT_SIZE_SELECT,
  input wire ENTER_PERIODIC,
  // Mode status
  output reg INIT_COMPLETE_FLAG,
  output reg PERIODIC_COLLECTION_MODE,
  output reg DIAG_MODE_ACTIVE,
  // Responses
  output reg RESERVED_RESP_REQ,
  output reg [31:0] RESERVED_RESP_WORD,
  output reg PERIODIC_RESP_REQ,
  output reg DIAG_CMD_VALID,
  output reg [31:0] DIAG_CMD_WORD,
  output reg [5:0] DIAG_BIT_COUNT
);

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------

  // Codes without a defined function
  function is_reserved;
    input [3:0] code;
    begin
      is_reserved = (code != `DPBC_CODE_DEF0) && (code != `DPBC_CODE_WRITE) &&
                    (code != `DPBC_CODE_PERIODIC);
    end
  endfunction

  // Check byte of a word matches its leading 24 bits
  function crc_ok;
    input [31:0] word;
    input [7:0] calc;
    begin
      crc_ok = (word[`DPBC_CRC_MSB:`DPBC_CRC_LSB] == calc);
    end
  endfunction

  // Accumulator with the newest fragment appended at the bottom
  function [31:0] shift_frag;
    input [31:0] word;
    input [3:0] bits;
    input wide;
    begin
      if (wide) begin
        shift_frag = {word[27:0], bits};
      end else begin
        shift_frag = {word[29:0], bits[1:0]};
      end
    end
  endfunction

  //----------------------------------------------------------------
  // Check byte units
  //----------------------------------------------------------------

  reg [31:0] accum;
  reg [31:0] next_accum;
  wire [31:0] shifted_accum;
  wire [7:0] rx_crc;
  wire [7:0] diag_crc;
  wire [7:0] echo_crc;
  wire [23:0] echo_head;

  // Both command paths use instances of the same check byte module, so the rule cannot drift
  dpbc_crc8 u_rx_crc (
    .msg(CMD_DATA[31:8]),
    .crc(rx_crc)
  );

  // Candidate word is formed outside the decode process, so the check
  // byte unit never sits in a loop through that process
  assign shifted_accum = shift_frag(accum, CMD_DATA[3:0], FRAGMENT_SIZE_SELECT);

  dpbc_crc8 u_diag_crc (
    .msg(shifted_accum[31:8]),
    .crc(diag_crc)
  );

  // Echo head: own address, received code, data held at zero
  assign echo_head = {NODE_ADDRESS_REG, CMD_DATA[`DPBC_CODE_MSB:`DPBC_CODE_LSB], 16'h0000};

  dpbc_crc8 u_echo_crc (
    .msg(echo_head),
    .crc(echo_crc)
  );

  //----------------------------------------------------------------
  // Command decode
  //----------------------------------------------------------------

  // A command is taken on the edge where CMD_VALID is high; every answer
  // below is a one-cycle strobe on the following edge
  wire full_cmd = CMD_VALID && (CMD_LEN == `DPBC_LEN_FULL);
  wire addr_hit = (CMD_DATA[`DPBC_ADDR_MSB:`DPBC_ADDR_LSB] == NODE_ADDRESS_REG);
  wire [5:0] frag_len = FRAGMENT_SIZE_SELECT ? `DPBC_LEN_FRAG4 : `DPBC_LEN_FRAG2;
  wire is_bcast = (CMD_LEN == `DPBC_LEN_BCAST); // value of the bit ignored
  wire is_frag = (CMD_LEN == frag_len);
  wire diag_on = INIT_COMPLETE_FLAG && DIAG_MODE_ENABLE;

  reg [5:0] next_count;
  reg next_diag_valid;
  reg next_periodic_resp;

  // Fragment assembly and periodic reply selection
  always @* begin
    next_accum = accum;
    next_count = DIAG_BIT_COUNT;
    next_diag_valid = 1'b0;
    next_periodic_resp = 1'b0;
    if (CMD_VALID && INIT_COMPLETE_FLAG) begin
      if (!diag_on) begin
        next_periodic_resp = is_bcast;
        next_count = `DPBC_RST_COUNT;
      end else if (is_frag) begin
        next_periodic_resp = 1'b1;
        // Newest bits enter at the bottom, so the first sent ends at the top
        next_accum = shifted_accum;
        next_count = DIAG_BIT_COUNT + frag_len;
        if (next_count == `DPBC_LEN_FULL) begin
          next_diag_valid = crc_ok(shifted_accum, diag_crc);
          next_count = `DPBC_RST_COUNT;
        end else if (next_count > `DPBC_LEN_FULL) begin
          // Size changed mid-word and ran past 32: drop it; a mixed word that lands on 32 is still tested
          next_count = `DPBC_RST_COUNT;
        end
      end else begin
        // Reads, wrong-size fragments and any other length restart assembly
        next_periodic_resp = is_bcast;
        next_count = `DPBC_RST_COUNT;
      end
    end
  end

  //----------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------

  // Mode flags; the init flag has no clear path besides reset
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      INIT_COMPLETE_FLAG <= `DPBC_RST_FLAG;
      PERIODIC_COLLECTION_MODE <= `DPBC_RST_FLAG;
      DIAG_MODE_ACTIVE <= `DPBC_RST_FLAG;
    end else begin
      if (ENTER_PERIODIC) begin
        INIT_COMPLETE_FLAG <= 1'b1;
      end
      PERIODIC_COLLECTION_MODE <= INIT_COMPLETE_FLAG;
      DIAG_MODE_ACTIVE <= diag_on;
    end
  end

  // Reserved command echo, only while command mode is alive
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      RESERVED_RESP_REQ <= `DPBC_RST_FLAG;
      RESERVED_RESP_WORD <= `DPBC_RST_WORD;
    end else begin
      RESERVED_RESP_REQ <= 1'b0;
      // Command mode is shut once periodic mode is on
      if (full_cmd && !INIT_COMPLETE_FLAG && addr_hit && crc_ok(CMD_DATA, rx_crc) &&
          is_reserved(CMD_DATA[`DPBC_CODE_MSB:`DPBC_CODE_LSB])) begin
        RESERVED_RESP_REQ <= 1'b1;
        RESERVED_RESP_WORD <= {echo_head, echo_crc};
      end
    end
  end

  // Periodic reply strobe and diagnostic assembly state
  // The diagnostic word holds until the next good assembly, so a reader need not race the strobe
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      accum <= `DPBC_RST_WORD;
      DIAG_BIT_COUNT <= `DPBC_RST_COUNT;
      PERIODIC_RESP_REQ <= `DPBC_RST_FLAG;
      DIAG_CMD_VALID <= `DPBC_RST_FLAG;
      DIAG_CMD_WORD <= `DPBC_RST_WORD;
    end else begin
      accum <= next_accum;
      DIAG_BIT_COUNT <= next_count;
      PERIODIC_RESP_REQ <= next_periodic_resp;
      DIAG_CMD_VALID <= next_diag_valid;
      if (next_diag_valid) begin
        DIAG_CMD_WORD <= next_accum;
      end
    end
  end

endmodule // dpbc_command_decode

// >>> dpbc_map.vh
`ifndef DPBC_MAP_VH
`define DPBC_MAP_VH

// Command word layout: address, command code, data, check byte
`define DPBC_CMD_BITS 32
`define DPBC_ADDR_MSB 31
`define DPBC_ADDR_LSB 28
`define DPBC_CODE_MSB 27
`define DPBC_CODE_LSB 24
`define DPBC_DATA_MSB 23
`define DPBC_DATA_LSB 8
`define DPBC_CRC_MSB 7
`define DPBC_CRC_LSB 0

// Check byte generator
`define DPBC_CRC_POLY 8'h1d
`define DPBC_CRC_SEED 8'hff

// Command lengths in bits
`define DPBC_LEN_BCAST 6'h01
`define DPBC_LEN_FRAG2 6'h02
`define DPBC_LEN_FRAG4 6'h04
`define DPBC_LEN_FULL 6'h20

// Defined command codes; all others are reserved
`define DPBC_CODE_DEF0 4'h0
`define DPBC_CODE_WRITE 4'h8
`define DPBC_CODE_PERIODIC 4'hb

// Reset values
`define DPBC_RST_FLAG 1'b0
`define DPBC_RST_WORD 32'h00000000
`define DPBC_RST_COUNT 6'h00

`endif

// >>> dpbc_crc8.v
`timescale 1ns/1ps
`include "dpbc_map.vh"

// Combinational 8-bit check byte over the 24 leading bits, MSB first
module dpbc_crc8 (
  // Message bits
  input wire [23:0] msg,
  // Resulting check byte
  output reg [7:0] crc
);

  integer i;
  reg fb;

  // Serial LFSR unrolled by the loop
  always @* begin
    crc = `DPBC_CRC_SEED;
    fb = 1'b0;
    for (i = 23; i >= 0; i = i - 1) begin
      fb = crc[7] ^ msg[i];
      crc = {crc[6:0], 1'b0} ^ (fb ? `DPBC_CRC_POLY : 8'h00);
    end
  end

endmodule // dpbc_crc8

// >>> dpbc_master_model.sv
`timescale 1ns/1ps
// --------
// Master side: hands commands to the decoder
// --------
module dpbc_master_model (
  // Clock
  input wire MCLK,
  // Command handed over
  output reg CMD_VALID,
  output reg [5:0] CMD_LEN,
  output reg [31:0] CMD_DATA
);
  // Idle until the first command
  initial begin
    CMD_VALID = 1'b0;
    CMD_LEN = 6'h00;
    CMD_DATA = 32'h00000000;
  end
  // One command per call, same word layout in every mode
  task send(input [5:0] len, input [31:0] data);
    begin
      @(posedge MCLK);
      #1 CMD_VALID = 1'b1;
      CMD_LEN = len;
      CMD_DATA = data;
      @(posedge MCLK);
      #1 CMD_VALID = 1'b0;
      CMD_DATA = ~data; // Stale data must not look valid
    end
  endtask
endmodule // dpbc_master_model

// >>> dpbc_command_decode_assertions.sv
`timescale 1ns/1ps
// --------
// Port checker
// --------
module dpbc_command_decode_assertions (
  // Inputs
  input wire MCLK,
  input wire RST_B,
  input wire CMD_VALID,
  input wire [5:0] CMD_LEN,
  input wire [31:0] CMD_DATA,
  input wire [3:0] NODE_ADDRESS_REG,
  input wire DIAG_MODE_ENABLE,
  input wire FRAGMENT_SIZE_SELECT,
  input wire ENTER_PERIODIC,
  // Outputs
  input wire INIT_COMPLETE_FLAG,
  input wire PERIODIC_COLLECTION_MODE,
  input wire DIAG_MODE_ACTIVE,
  input wire RESERVED_RESP_REQ,
  input wire [31:0] RESERVED_RESP_WORD,
  input wire DIAG_CMD_VALID,
  input wire PERIODIC_RESP_REQ,
  input wire [5:0] DIAG_BIT_COUNT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  reg [31:0] last_data;
  // Command word of the previous edge, for the echo check
  always @(posedge MCLK) last_data <= CMD_DATA;
  // Command classes seen in periodic mode
  wire rd = CMD_VALID && INIT_COMPLETE_FLAG && CMD_LEN == 6'h01;
  wire fr = CMD_VALID && INIT_COMPLETE_FLAG && DIAG_MODE_ENABLE
    && CMD_LEN == (FRAGMENT_SIZE_SELECT ? 6'h04 : 6'h02);
  flag_sticky_a: assert property (INIT_COMPLETE_FLAG |=> INIT_COMPLETE_FLAG)
    else $error("init flag dropped");
  flag_set_a: assert property (ENTER_PERIODIC |=> INIT_COMPLETE_FLAG)
    else $error("init flag not set");
  mode_copy_a: assert property (PERIODIC_COLLECTION_MODE == $past(INIT_COMPLETE_FLAG))
    else $error("periodic status wrong");
  diag_gate_a: assert property (DIAG_MODE_ACTIVE ==
    ($past(INIT_COMPLETE_FLAG) && $past(DIAG_MODE_ENABLE))) else $error("diag status wrong");
  no_echo_a: assert property (INIT_COMPLETE_FLAG |=> !RESERVED_RESP_REQ)
    else $error("echo in periodic mode");
  echo_head_a: assert property (RESERVED_RESP_REQ |-> $past(CMD_VALID) &&
    RESERVED_RESP_WORD[31:24] == {NODE_ADDRESS_REG, last_data[27:24]}) else $error("bad echo");
  addr_drop_a: assert property (CMD_VALID && CMD_DATA[31:28] != NODE_ADDRESS_REG
    |=> !RESERVED_RESP_REQ) else $error("echo for other node");
  read_resp_a: assert property (rd |=> PERIODIC_RESP_REQ)
    else $error("read not answered");
  frag_resp_a: assert property (fr |=> PERIODIC_RESP_REQ)
    else $error("fragment not answered");
  no_resp_a: assert property (!rd && !fr |=> !PERIODIC_RESP_REQ)
    else $error("spurious periodic answer");
  read_clear_a: assert property (rd |=> DIAG_BIT_COUNT == 6'h00)
    else $error("count not cleared");
  diag_done_a: assert property (DIAG_CMD_VALID |->
    DIAG_BIT_COUNT == 6'h00 && $past(CMD_VALID)) else $error("early diag command");
endmodule // dpbc_command_decode_assertions

bind dpbc_command_decode dpbc_command_decode_assertions chk (.*);

// >>> dpbc_command_decode_test.sv
`timescale 1ns/1ps
// --------
// Self-checking bench
// --------
module dpbc_command_decode_test;
  reg MCLK = 1'b0, RST_B = 1'b0, den = 1'b0, fsel = 1'b0, enter = 1'b0;
  reg [3:0] node = 4'h5;
  reg [31:0] w, k;
  wire vld, flag, periodic_collection_mode, dact, ereq, preq, dok;
  wire [5:0] len, cnt;
  wire [31:0] dat, eword, dword;
  integer miscompares = 0, num_checks = 0, i;
  always #5 MCLK = ~MCLK;
  dpbc_master_model m (.MCLK(MCLK), .CMD_VALID(vld), .CMD_LEN(len), .CMD_DATA(dat));
  dpbc_command_decode uut (.MCLK(MCLK), .RST_B(RST_B), .CMD_VALID(vld), .CMD_LEN(len),
    .CMD_DATA(dat), .NODE_ADDRESS_REG(node), .DIAG_MODE_ENABLE(den),
    .FRAGMENT_SIZE_SELECT(fsel), .ENTER_PERIODIC(enter), .INIT_COMPLETE_FLAG(flag),
    .PERIODIC_COLLECTION_MODE(periodic_collection_mode), .DIAG_MODE_ACTIVE(dact), .RESERVED_RESP_REQ(ereq),
    .RESERVED_RESP_WORD(eword), .PERIODIC_RESP_REQ(preq), .DIAG_CMD_VALID(dok),
    .DIAG_CMD_WORD(dword), .DIAG_BIT_COUNT(cnt));
  // Head plus check byte, MSB first, no final inversion
  function [31:0] seal(input [23:0] h);
    reg [7:0] c;
    integer j;
    begin
      c = 8'hff;
      for (j = 23; j >= 0; j = j - 1) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[j]) ? 8'h1d : 8'h00);
      seal = {h, c};
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Whole word as fragments, earliest bits first
  task frags(input [31:0] x, input [5:0] n);
    for (i = 32 - n; i >= 0; i = i - n) begin
      m.send(n, (x >> i) & ((32'h1 << n) - 1));
      check(preq, 1);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Watchdog far beyond the roughly 150 cycles needed
  initial begin
    #100000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge MCLK);
    #1 RST_B = 1'b1;
    // Every code to own node with good check byte
    for (k = 0; k < 16; k = k + 1) begin
      m.send(6'h20, seal({node, k[3:0], 16'habcd}));
      check(ereq, k != 0 && k != 8 && k != 11);
      if (k == 1) check(eword, seal({node, 4'h1, 16'h0000}));
    end
    m.send(6'h20, seal({node, 4'h1, 16'h0}) ^ 32'h1);
    check(ereq, 0);
    m.send(6'h20, seal({~node, 4'h1, 16'h0}));
    check(ereq, 0);
    m.send(6'h01, 0);
    check(preq, 0);
    @(posedge MCLK) #1 enter = 1'b1;
    @(posedge MCLK) #1 enter = 1'b0;
    check(flag, 1);
    m.send(6'h20, seal({node, 4'h2, 16'h0}));
    check(ereq, 0);
    check({periodic_collection_mode, dact}, 2'b10);
    m.send(6'h01, 0);
    check(preq, 1);
    m.send(6'h01, 1);
    check(preq, 1);
    m.send(6'h02, 2);
    check(preq, 0);
    // Diagnostic commands, 4-bit then 2-bit
    den = 1'b1;
    fsel = 1'b1;
    w = seal(24'h381234);
    frags(w, 4);
    check(dok, 1);
    check(dword, w);
    check(dact, 1);
    fsel = 1'b0;
    frags(w ^ 32'h1, 2);
    check(dok, 0);
    check(dword, w);
    m.send(6'h02, 3);
    m.send(6'h02, 1);
    check(cnt, 4);
    m.send(6'h01, 0);
    check(cnt, 0);
    m.send(6'h02, 1);
    m.send(6'h04, 5);
    check({preq, cnt}, 0);
    frags(w, 2);
    check(dok, 1);
    // Reset in mid-run clears the flag and all mode status
    @(posedge MCLK) #1 RST_B = 1'b0;
    @(posedge MCLK) #1 RST_B = 1'b1;
    check(flag, 0);
    check({periodic_collection_mode, dact, cnt}, 0);
    tally_and_finish;
  end
endmodule // dpbc_command_decode_test
